// ### core/rtcs_consts.svh
// Constants of the two-wire register-space slave
`ifndef RTCS_CONSTS_SVH
`define RTCS_CONSTS_SVH
`define RTCS_DEV_ID 7'h6f
`define RTCS_PAGE_BYTES 8
`define RTCS_SPACE_BYTES 64
`define RTCS_STATUS_ADDR 16'h003f
`define RTCS_STAT_CLR 8'h00
`define RTCS_STAT_WEL 8'h02
`define RTCS_STAT_REGISTER_WRITE_LATCH 8'h06
`define RTCS_CLK_HZ 25000000
`define RTCS_TWC_US 5000
`define RTCS_TWC_CYC (`RTCS_TWC_US * (`RTCS_CLK_HZ / 1000000))
`endif

// ### core/rtcs_pkg.sv
// Types of the two-wire register-space slave
package rtcs_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA,
		ST_WAIT
	} rtcs_state_type;

	typedef struct packed {
		logic nv_busy;
		logic register_write_latch;
		logic write_enable_latch;
	} rtcs_status_type;
endpackage

// ### core/rtcs_slave.sv
// Two-wire serial slave for the clock/control register space
// Behaviour
// - Page write accepts up to seven more bytes
// - Acknowledge each data byte, then increment address
// - Write address wraps within the same page
// - Extra bytes overwrite earlier ones, wrapped address
// - Stop after data starts nonvolatile write cycle when register write latch set, except to the status address
// - Bus ignored while nonvolatile cycle runs
// - Early or mid-byte stop abandons the write
// - No acknowledge while busy, acknowledge after
// - Counter holds last read address plus one
// - Read address byte acknowledged, byte shifted out
// - Stop after address bytes just sets address
// - Master acknowledge fetches next consecutive byte
// - Read counter wraps at end of space
// - Identifier 1101 and select bits 111
// - Address byte bit 0 selects read or write
// - Acknowledge only when upper seven bits match
// - Two address bytes follow, else counter used
// - No data acknowledge while enable latch cleared, except to the status address
// - Cycle completion clears the register write latch
`timescale 1ns/1ps
`include "rtcs_consts.svh"
module rtcs_slave
	import rtcs_pkg::*;
#(
	parameter int DEPTH = `RTCS_SPACE_BYTES,
	parameter int TWC_CYCLES = `RTCS_TWC_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output rtcs_status_type status
);
	localparam int PAGE = `RTCS_PAGE_BYTES;
	localparam int AW = $clog2(DEPTH);
	localparam int PW = $clog2(PAGE);
	localparam int CW = $clog2(TWC_CYCLES + 1);

	generate
		if (DEPTH != (1 << AW) || AW <= PW || AW > 16 || TWC_CYCLES < 2) begin : g_bad_params
			$error("rtcs_slave: DEPTH must be a power of two above one page, TWC_CYCLES at least 2");
		end
	endgenerate

	// Link side: each SCL rise captures SDA and flips a toggle
	logic bit_tgl_q;
	logic bit_cap_q;
	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn) begin
			bit_tgl_q <= 1'b0;
			bit_cap_q <= 1'b0;
		end else begin
			bit_tgl_q <= ~bit_tgl_q;
			bit_cap_q <= sda_in;
		end
	end

	// Synchronisers; the captured bit is only read after its toggle has crossed
	logic [2:0] tgl_s_q;
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tgl_s_q <= 3'h0;
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
		end else begin
			tgl_s_q <= {tgl_s_q[1:0], bit_tgl_q};
			scl_s_q <= {scl_s_q[1:0], scl};
			sda_s_q <= {sda_s_q[1:0], sda_in};
		end
	end

	wire rise_ev = tgl_s_q[2] ^ tgl_s_q[1];
	wire fall_ev = scl_s_q[2] & ~scl_s_q[1];
	wire scl_hi = scl_s_q[2] & scl_s_q[1];
	wire start_ev = scl_hi & sda_s_q[2] & ~sda_s_q[1];
	wire stop_ev = scl_hi & ~sda_s_q[2] & sda_s_q[1];

	rtcs_state_type state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic ack_q;
	logic sda_oe_n_q;
	logic [7:0] tx_q;
	logic [AW-1:0] addr_q;
	logic [7:0] addr_hi_q;
	logic to_status_q;
	logic got_byte_q;
	logic [PAGE-1:0] mask_q;
	logic [7:0] last_byte_q;
	logic [7:0] page_q [PAGE];
	logic [7:0] mem_q [DEPTH];
	logic wel_q;
	logic register_write_latch_q;
	logic nv_busy_q;
	logic [CW-1:0] busy_cnt_q;

	function automatic logic [AW-1:0] page_next(input logic [AW-1:0] a);
		page_next = {a[AW-1:PW], PW'(a[PW-1:0] + 1'b1)};
	endfunction

	function automatic logic page_hit(input logic [AW-1:0] a, input logic [AW-1:0] loc,
			input logic [PAGE-1:0] mask);
		page_hit = (a[AW-1:PW] == loc[AW-1:PW]) && mask[loc[PW-1:0]];
	endfunction

	wire active = !nv_busy_q;
	wire [7:0] rx_byte = {shift_q[6:0], bit_cap_q};
	wire in_frame = state_q != ST_IDLE && state_q != ST_WAIT;
	wire rx_phase = active && rise_ev && in_frame && bit_cnt_q != 4'd8;
	wire ack_phase = active && rise_ev && in_frame && bit_cnt_q == 4'd8;
	wire last_bit = rx_phase && bit_cnt_q == 4'd7;
	wire dev_match = rx_byte[7:1] == `RTCS_DEV_ID;
	wire [15:0] addr_full = {addr_hi_q, shift_q};
	wire [PW-1:0] wr_off = addr_q[PW-1:0];

	// Acknowledge decision made as the eighth bit lands
	wire ack_dec = (state_q == ST_DEV) ? dev_match :
		(state_q == ST_ADDR_HI || state_q == ST_ADDR_LO) ? 1'b1 :
		(state_q == ST_WDATA) ? (to_status_q || wel_q) : 1'b0;

	wire dev_read = state_q == ST_DEV && ack_q && shift_q[0];
	wire wr_step = ack_phase && state_q == ST_WDATA && ack_q;
	wire rd_load = ack_phase && (dev_read || (state_q == ST_RDATA && !bit_cap_q));

	// A nack from the master drops to waiting for its stop
	rtcs_state_type state_ack;
	assign state_ack = (state_q == ST_DEV) ? (!ack_q ? ST_WAIT : shift_q[0] ? ST_RDATA : ST_ADDR_HI) :
		(state_q == ST_ADDR_HI) ? ST_ADDR_LO :
		(state_q == ST_ADDR_LO) ? ST_WDATA :
		(state_q == ST_WDATA) ? (ack_q ? ST_WDATA : ST_WAIT) :
		(state_q == ST_RDATA) ? (bit_cap_q ? ST_WAIT : ST_RDATA) : ST_WAIT;

	wire drive_low = (bit_cnt_q == 4'd8 && ack_q) ||
		(state_q == ST_RDATA && bit_cnt_q < 4'd8 && !tx_q[3'd7 - bit_cnt_q[2:0]]);

	// The stop's own SCL rise lands as bit one of a new byte
	wire stop_ok = bit_cnt_q <= 4'd1;
	wire commit = active && stop_ev && state_q == ST_WDATA && stop_ok && got_byte_q;
	wire commit_status = commit && to_status_q;
	wire commit_nv = commit && !to_status_q && register_write_latch_q;
	wire nv_end = busy_cnt_q == CW'(1);
	wire stat_ok = last_byte_q == `RTCS_STAT_CLR || last_byte_q == `RTCS_STAT_WEL ||
		last_byte_q == `RTCS_STAT_REGISTER_WRITE_LATCH;

	// Protocol sequencer; busy forces idle so starts and polls go unanswered
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			ack_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (!active || start_ev || stop_ev) begin
			state_q <= (active && start_ev) ? ST_DEV : ST_IDLE;
			bit_cnt_q <= 4'h0;
			ack_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else begin
			if (fall_ev) begin
				sda_oe_n_q <= ~drive_low;
			end
			if (rx_phase) begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
			if (last_bit) begin
				ack_q <= ack_dec;
			end
			if (ack_phase) begin
				bit_cnt_q <= 4'h0;
				ack_q <= 1'b0;
				state_q <= state_ack;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shift_q <= 8'h00;
		end else if (rx_phase) begin
			shift_q <= rx_byte;
		end
	end

	// Address counter, page mask and read fetch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_q <= '0;
			addr_hi_q <= 8'h00;
			to_status_q <= 1'b0;
			got_byte_q <= 1'b0;
			mask_q <= '0;
			last_byte_q <= 8'h00;
			tx_q <= 8'h00;
		end else begin
			if (ack_phase && state_q == ST_ADDR_HI) begin
				addr_hi_q <= shift_q;
			end
			if (ack_phase && state_q == ST_ADDR_LO) begin
				addr_q <= addr_full[AW-1:0];
				to_status_q <= addr_full == `RTCS_STATUS_ADDR;
				got_byte_q <= 1'b0;
				mask_q <= '0;
			end else if (wr_step) begin
				addr_q <= page_next(addr_q);
				got_byte_q <= 1'b1;
				mask_q[wr_off] <= 1'b1;
				last_byte_q <= shift_q;
			end else if (rd_load) begin
				addr_q <= AW'(addr_q + 1'b1);
			end
			if (rd_load) begin
				tx_q <= mem_q[addr_q];
			end
		end
	end

	// Page buffer; a ninth byte lands on the first slot again
	generate
		for (genvar j = 0; j < PAGE; j++) begin : g_page
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					page_q[j] <= 8'h00;
				end else if (wr_step && wr_off == PW'(j)) begin
					page_q[j] <= shift_q;
				end
			end
		end
	endgenerate

	// Register space is written only when the nonvolatile cycle starts
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_mem
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					mem_q[i] <= 8'h00;
				end else if (commit_nv && page_hit(addr_q, AW'(i), mask_q)) begin
					mem_q[i] <= page_q[i % PAGE];
				end
			end
		end
	endgenerate

	// Volatile latches; other status values leave both unchanged
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wel_q <= 1'b0;
			register_write_latch_q <= 1'b0;
		end else if (commit_status && stat_ok) begin
			wel_q <= last_byte_q[1];
			register_write_latch_q <= last_byte_q[2];
		end else if (nv_end) begin
			register_write_latch_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy_cnt_q <= '0;
			nv_busy_q <= 1'b0;
		end else if (commit_nv) begin
			busy_cnt_q <= CW'(TWC_CYCLES);
			nv_busy_q <= 1'b1;
		end else if (busy_cnt_q != '0) begin
			busy_cnt_q <= busy_cnt_q - CW'(1);
			nv_busy_q <= !nv_end;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe_n = sda_oe_n_q;
	assign status = '{nv_busy: nv_busy_q, register_write_latch: register_write_latch_q, write_enable_latch: wel_q};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_stop_after_byte;
		active && stop_ev && state_q == ST_WDATA && stop_ok && got_byte_q;
	endsequence

	sequence s_dev_read_ack;
		ack_phase && state_q == ST_DEV && ack_q && shift_q[0];
	endsequence

	chk_nv_start_len: assert property (
		s_stop_after_byte ##0 (register_write_latch_q && !to_status_q) |=> nv_busy_q ##1 (busy_cnt_q == CW'(TWC_CYCLES - 1)))
		else $error("stop after data did not start the write cycle");
	chk_nv_end_register_write_latch: assert property ($fell(nv_busy_q) |-> !register_write_latch_q && busy_cnt_q == '0)
		else $error("register write latch survived cycle end");
	chk_busy_quiet: assert property (nv_busy_q |-> sda_oe_n_q && state_q == ST_IDLE)
		else $error("bus answered while busy");
	chk_mid_abort: assert property (
		active && stop_ev && state_q == ST_WDATA && bit_cnt_q > 4'd1 && !nv_busy_q |=> !nv_busy_q [*2])
		else $error("mid-byte stop started a write");
	chk_dev_match_ack: assert property (last_bit && state_q == ST_DEV |=> ack_q == (shift_q[7:1] == `RTCS_DEV_ID))
		else $error("address byte acknowledge wrong");
	chk_wel_nack: assert property (
		last_bit && state_q == ST_WDATA && !wel_q && !to_status_q |=> !ack_q)
		else $error("data acknowledged with enable latch clear");
	chk_page_wrap: assert property (wr_step |=> addr_q == page_next($past(addr_q)))
		else $error("write address left its page");
	chk_read_next: assert property (rd_load |=> addr_q == AW'($past(addr_q) + 1'b1))
		else $error("read counter did not step");
	chk_dev_read: assert property (s_dev_read_ack |=> state_q == ST_RDATA ##0 tx_q == mem_q[$past(addr_q)])
		else $error("read address byte did not start a read");
	chk_commit_no_latch: assert property (
		s_stop_after_byte ##0 (!register_write_latch_q && !to_status_q) |=> !nv_busy_q)
		else $error("write started without the register write latch");
	chk_status_ack: assert property (last_bit && state_q == ST_WDATA && to_status_q |=> ack_q)
		else $error("status data byte not acknowledged");
	chk_addr_load: assert property (ack_phase && state_q == ST_ADDR_LO |=> addr_q == addr_full[AW-1:0])
		else $error("register address not loaded");
	chk_status_set: assert property (commit_status && last_byte_q == `RTCS_STAT_REGISTER_WRITE_LATCH |=> wel_q && register_write_latch_q)
		else $error("status write did not set both latches");
	chk_status_clear: assert property (commit_status && last_byte_q == `RTCS_STAT_CLR |=> !wel_q && !register_write_latch_q)
		else $error("status clear left a latch set");

	// Read continues only on a master acknowledge
	sequence s_read_ack_slot;
		ack_phase && state_q == ST_RDATA;
	endsequence
	chk_read_more: assert property (
		s_read_ack_slot ##0 !bit_cap_q |=> state_q == ST_RDATA && bit_cnt_q == 4'd0)
		else $error("master acknowledge did not continue the read");
	chk_read_stop: assert property (
		s_read_ack_slot ##0 bit_cap_q |=> state_q == ST_WAIT && addr_q == $past(addr_q))
		else $error("master nack advanced the read");
	chk_ack_release: assert property (
		active && fall_ev && state_q == ST_RDATA && bit_cnt_q == 4'd8 |=> sda_oe_n_q)
		else $error("read acknowledge slot not released");
endmodule

// ### verif/rtcs_master.sv
// Two-wire bus master model facing the slave
`timescale 1ns/1ps
module rtcs_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_oe_n
);
	initial begin
		scl = 1'b1;
		sda_oe_n = 1'b1;
	end
	// 11 clk per phase, above the 3-stage synchronisers of the slave
	task automatic half;
		repeat (11) @(negedge clk);
	endtask
	task automatic start;
		sda_oe_n = 1'b1;
		half;
		scl = 1'b1;
		half;
		sda_oe_n = 1'b0;
		half;
		scl = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic stop;
		sda_oe_n = 1'b0;
		half;
		scl = 1'b1;
		half;
		sda_oe_n = 1'b1;
		half;
	endtask
	// Data moves a few clk after the fall, clear of start/stop
	task automatic bit_x(input logic b, output logic r);
		sda_oe_n = b;
		half;
		scl = 1'b1;
		half;
		r = sda;
		scl = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] d, input int n, output logic ack);
		logic r;
		ack = 1'b0;
		for (int i = 7; i > 7 - n; i--) bit_x(d[i], r);
		if (n == 8) begin
			bit_x(1'b1, r);
			ack = ~r;
		end
	endtask
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(last, r);
	endtask
endmodule

// ### verif/rtcs_slave_tb_top.sv
// Testbench of the two-wire register-space slave
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rtcs_slave_tb_top
	import rtcs_pkg::*;
;
	localparam int TWC = 600;
	localparam int LIMIT = 60000;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic scl, m_oe_n, sda_out, sda_oe_n, ack;
	logic [7:0] d;
	rtcs_status_type status;
	int n_tests = 0;
	int n_mismatch = 0;
	int cyc = 0;
	int busy_len = 0;
	// Pull-up: wire is high unless a party pulls it
	wire sda = (sda_oe_n ? 1'b1 : sda_out) & m_oe_n;
	initial begin
		forever #20 clk = ~clk;
	end
	rtcs_slave #(.DEPTH(64), .TWC_CYCLES(TWC)) rtcs_slave_i (.clk(clk), .resetn(resetn), .scl(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .status(status));
	rtcs_master rtcs_master_i (.clk(clk), .sda(sda), .scl(scl), .sda_oe_n(m_oe_n));
	task automatic stop_test;
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(negedge clk) begin
		cyc++;
		if (status.nv_busy === 1'b1) busy_len++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			stop_test;
		end
	end
	task automatic sel(input logic [7:0] a, input logic e);
		rtcs_master_i.start;
		rtcs_master_i.wr(a, 8, ack);
		`CHK(ack, e)
	endtask
	task automatic put(input logic [7:0] v, input logic e);
		rtcs_master_i.wr(v, 8, ack);
		`CHK(ack, e)
	endtask
	task automatic at(input logic [15:0] a);
		sel(8'hde, 1'b1);
		put(a[15:8], 1'b1);
		put(a[7:0], 1'b1);
	endtask
	task automatic stat(input logic [7:0] v, input rtcs_status_type e);
		at(16'h003f);
		put(v, 1'b1);
		rtcs_master_i.stop;
		`CHK(status, e)
	endtask
	task automatic get(input logic last, input logic [7:0] e);
		rtcs_master_i.rd(last, d);
		`CHK(d, e)
	endtask
	// Last of ten bytes written from slot 5 that lands in slot a
	function automatic logic [7:0] page_val(input int a);
		int k;
		k = (a + 3) % 8;
		if (k < 2) k += 8;
		return 8'h10 + k[7:0];
	endfunction
	initial begin
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(status, 3'b000)
		`CHK(sda_oe_n, 1'b1)
		sel(8'hdf, 1'b1);
		get(1'b1, 8'h00);
		rtcs_master_i.stop;
		sel(8'hd0, 1'b0);
		rtcs_master_i.stop;
		sel(8'h5e, 1'b0);
		rtcs_master_i.stop;
		at(16'h0000);
		put(8'h55, 1'b0);
		rtcs_master_i.stop;
		$display("test address and refusal done");
		stat(8'h02, 3'b001);
		stat(8'h06, 3'b011);
		at(16'h0005);
		for (int i = 0; i < 10; i++) put(8'h10 + i[7:0], 1'b1);
		busy_len = 0;
		rtcs_master_i.stop;
		sel(8'hde, 1'b0);
		rtcs_master_i.stop;
		for (int i = 0; i < 2 * TWC && status.nv_busy !== 1'b0; i++) @(negedge clk);
		`CHK(busy_len, TWC)
		`CHK(status, 3'b001)
		$display("test page write done");
		at(16'h0000);
		sel(8'hdf, 1'b1);
		for (int a = 0; a < 8; a++) get(a == 7, page_val(a));
		rtcs_master_i.stop;
		sel(8'hdf, 1'b1);
		get(1'b1, 8'h00);
		rtcs_master_i.stop;
		at(16'h003e);
		rtcs_master_i.stop;
		sel(8'hdf, 1'b1);
		get(1'b0, 8'h00);
		get(1'b0, 8'h00);
		get(1'b1, page_val(0));
		rtcs_master_i.stop;
		$display("test reads done");
		stat(8'h02, 3'b001);
		stat(8'h06, 3'b011);
		busy_len = 0;
		at(16'h0010);
		rtcs_master_i.wr(8'hff, 4, ack);
		rtcs_master_i.stop;
		at(16'h0010);
		put(8'haa, 1'b1);
		rtcs_master_i.wr(8'hff, 4, ack);
		rtcs_master_i.stop;
		`CHK(busy_len, 0)
		`CHK(status, 3'b011)
		at(16'h0010);
		sel(8'hdf, 1'b1);
		get(1'b1, 8'h00);
		rtcs_master_i.stop;
		$display("test early stop done");
		stat(8'h04, 3'b011);
		stat(8'h00, 3'b000);
		stat(8'h02, 3'b001);
		busy_len = 0;
		at(16'h0020);
		put(8'h77, 1'b1);
		rtcs_master_i.stop;
		`CHK(busy_len, 0)
		at(16'h0020);
		sel(8'hdf, 1'b1);
		get(1'b1, 8'h00);
		rtcs_master_i.stop;
		$display("test latch clear done");
		stop_test;
	end
endmodule
